// ==== hdl/cpx_exec_core.sv ====
// instruction execution subset with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module cpx_exec_core
   import cpx_pkg::*;
#(
   parameter int FILE_DEPTH = 128,
   parameter int STK_DEPTH  = 8,
   parameter int WDG_W      = 8,
   parameter int PRE_DIV    = 16
) (
   input  wire logic        ref_clk,   // core clock, 250 MHz
   input  wire logic        rstn,      // sync reset, active low
   input  wire logic        hsel,      // slave select
   input  wire logic [31:0] haddr,     // byte address
   input  wire logic [1:0]  htrans,    // transfer type
   input  wire logic        hwrite,    // write when high
   input  wire logic [2:0]  hsize,     // transfer size
   input  wire logic        hready,    // bus ready
   input  wire logic [31:0] hwdata,    // write data
   output logic      [31:0] hrdata,    // read data
   output logic             hreadyout, // slave ready
   output logic             hresp      // always okay
);
   localparam int SP_W  = $clog2(STK_DEPTH);
   localparam int PRE_W = $clog2(PRE_DIV);
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   generate
      if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_file
         $error("FILE_DEPTH must be 1 to 128");
      end
      if (STK_DEPTH < 2 || (STK_DEPTH & (STK_DEPTH - 1)) != 0) begin : g_bad_stk
         $error("STK_DEPTH must be a power of two");
      end
      if (PRE_DIV < 2 || WDG_W < 1 || WDG_W > 32) begin : g_bad_wdg
         $error("PRE_DIV must be >= 2 and WDG_W 1 to 32");
      end
   endgenerate

   // bus side state
   logic             wr_q;
   logic             rd_q;
   logic [7:0]       addr_q;
   logic [2:0]       hsize_q;
   logic [31:0]      hrdata_q;
   logic             hready_q;
   logic             hresp_q;

   // core state
   cpx_state_t       st_q;
   cpx_state_t       st_d;
   cpx_instr_t       ir_q;
   logic [7:0]       acc_q;
   logic [PC_W-1:0]  pc_q;
   logic [PC_W-1:0]  pc_d;
   logic [LT_W-1:0]  latch_q;
   logic [F_W-1:0]   fsel_q;
   logic             z_q;
   logic             to_n_q;
   logic             pwrdn_n_q;
   logic [SP_W-1:0]  sp_q;
   logic [PC_W-1:0]  stk_q [STK_DEPTH];
   logic [7:0]       file_q [FILE_DEPTH];
   logic [PRE_W-1:0] pre_q;
   logic [WDG_W-1:0] wdg_q;

   // bus address phase and write strobes
   wire logic take    = hsel & hready & htrans[1];
   wire logic idle    = (st_q == S_IDLE);
   wire logic wr_ok   = wr_q & (hsize_q == HSIZE_WORD);
   wire logic w_issue = wr_ok & (addr_q == A_ISSUE) & idle;
   wire logic w_acc   = wr_ok & (addr_q == A_ACC);
   wire logic w_stat  = wr_ok & (addr_q == A_STAT);
   wire logic w_pc    = wr_ok & (addr_q == A_PC) & idle;
   wire logic w_latch = wr_ok & (addr_q == A_LATCH);
   wire logic w_fsel  = wr_ok & (addr_q == A_FSEL);
   wire logic w_fdata = wr_ok & (addr_q == A_FDATA);

   // operand fetch and result
   wire logic       exec   = (st_q == S_EXEC);
   wire cpx_op_t    op     = ir_q.op;
   wire logic       f_in   = ({1'b0, ir_q.f} < 8'(FILE_DEPTH));
   wire logic [7:0] fval   = f_in ? file_q[ir_q.f] : 8'h00;
   wire logic       sel_in = ({1'b0, fsel_q} < 8'(FILE_DEPTH));
   wire logic [7:0] fsval  = sel_in ? file_q[fsel_q] : 8'h00;
   wire logic       is_dop = (op == OP_COMP) | (op == OP_DEC)
                           | (op == OP_DECSKIP);
   wire logic [7:0] res    = (op == OP_COMP) ? ~fval
                           : ((op == OP_DEC) | (op == OP_DECSKIP))
                           ? fval - 8'h01 : 8'h00;
   wire logic       res_z  = (res == 8'h00);

   wire logic to_acc  = exec & ((op == OP_CLR_ACC) | (is_dop & ~ir_q.d));
   wire logic to_file = exec & ((op == OP_CLR_REG) | (is_dop & ir_q.d));
   wire logic z_upd   = exec & (op != OP_DECSKIP) & (op != OP_WDCLR)
                      & (op != OP_CALL) & (op != OP_NOP);
   wire logic wdclr   = exec & (op == OP_WDCLR);
   wire logic push    = exec & (op == OP_CALL);
   // zero result forces the no-op cycle
   wire logic skip    = exec & (op == OP_DECSKIP) & res_z;

   // watchdog prescaler tick and counter overflow
   wire logic tick    = (pre_q == PRE_W'(PRE_DIV - 1));
   wire logic wdg_ovf = tick & (&wdg_q);

   wire logic [SP_W-1:0] sp_top = sp_q - SP_W'(1);

   wire cpx_stat_t stat = '{busy: ~idle, pwrdn_n: pwrdn_n_q,
                            to_n: to_n_q, z: z_q};

   // read data selection
   wire logic [31:0] rd_mux =
        (addr_q == A_ISSUE) ? 32'(ir_q)
      : (addr_q == A_ACC)   ? {24'h0, acc_q}
      : (addr_q == A_STAT)  ? {28'h0, stat}
      : (addr_q == A_PC)    ? {19'h0, pc_q}
      : (addr_q == A_LATCH) ? {27'h0, latch_q}
      : (addr_q == A_TOP)   ? {19'h0, stk_q[sp_top]}
      : (addr_q == A_WDG)   ? 32'(wdg_q)
      : (addr_q == A_FSEL)  ? {25'h0, fsel_q}
      : (addr_q == A_FDATA) ? {24'h0, fsval}
      : 32'h0000_0000;

   // bus slave: writes zero wait, reads one wait state
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         addr_q   <= 8'h00;
         hsize_q  <= 3'h0;
         hrdata_q <= 32'h0000_0000;
         hready_q <= 1'b1;
         hresp_q  <= 1'b0;
      end else begin
         wr_q     <= take & hwrite;
         rd_q     <= take & ~hwrite;
         hready_q <= ~(take & ~hwrite);
         hresp_q  <= 1'b0;
         if (take) begin
            addr_q  <= haddr[7:0];
            hsize_q <= hsize;
         end
         if (rd_q) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hready_q;
   assign hresp     = hresp_q;

   // sequencer next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         S_IDLE: begin
            if (w_issue) begin
               st_d = S_EXEC;
            end
         end
         S_EXEC: begin
            if (op == OP_CALL) begin
               st_d = S_CALL2;
            end else if (skip) begin
               st_d = S_SKIP;
            end else begin
               st_d = S_IDLE;
            end
         end
         S_CALL2: st_d = S_IDLE;
         S_SKIP:  st_d = S_IDLE;
         default: st_d = S_IDLE;
      endcase
   end

   // program counter next value
   always_comb begin
      pc_d = pc_q;
      case (st_q)
         S_IDLE: begin
            if (w_pc) begin
               pc_d = hwdata[PC_W-1:0];
            end
         end
         S_EXEC: begin
            if (op != OP_CALL) begin
               pc_d = pc_q + PC_W'(1);
            end
         end
         // literal and latch bits form the target
         S_CALL2: pc_d = {latch_q[LT_HI:LT_LO], ir_q.k};
         S_SKIP:  pc_d = pc_q + PC_W'(1);
         default: pc_d = pc_q;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st_q <= S_IDLE;
         pc_q <= PC_RST;
         ir_q <= '0;
      end else begin
         st_q <= st_d;
         pc_q <= pc_d;
         if (w_issue) begin
            ir_q <= cpx_instr_t'(hwdata);
         end
      end
   end

   // accumulator, latch and file select
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         acc_q   <= ACC_RST;
         latch_q <= LATCH_RST;
         fsel_q  <= '0;
      end else begin
         if (to_acc) begin
            acc_q <= res;
         end else if (w_acc) begin
            acc_q <= hwdata[7:0];
         end
         if (w_latch) begin
            latch_q <= hwdata[LT_W-1:0];
         end
         if (w_fsel) begin
            fsel_q <= hwdata[F_W-1:0];
         end
      end
   end

   // status bits; a watchdog timeout wins over a clear
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         z_q       <= 1'b0;
         to_n_q    <= 1'b1;
         pwrdn_n_q <= 1'b1;
      end else begin
         if (z_upd) begin
            z_q <= res_z;
         end else if (w_stat) begin
            z_q <= hwdata[0];
         end
         if (wdg_ovf) begin
            to_n_q <= 1'b0;
         end else if (wdclr) begin
            to_n_q <= 1'b1;
         end else if (w_stat) begin
            to_n_q <= hwdata[1];
         end
         if (wdclr) begin
            pwrdn_n_q <= 1'b1;
         end else if (w_stat) begin
            pwrdn_n_q <= hwdata[2];
         end
      end
   end

   // watchdog prescaler and counter
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pre_q <= '0;
         wdg_q <= '0;
      end else if (wdclr) begin
         pre_q <= '0;
         wdg_q <= '0;
      end else begin
         pre_q <= tick ? '0 : pre_q + PRE_W'(1);
         if (tick) begin
            wdg_q <= wdg_q + WDG_W'(1);
         end
      end
   end

   // return stack pointer, wraps when full
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sp_q <= '0;
      end else if (push) begin
         sp_q <= sp_q + SP_W'(1);
      end
   end

   // return stack entries; cleared so an early top read is defined
   genvar si;
   generate
      for (si = 0; si < STK_DEPTH; si++) begin : g_stk
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               stk_q[si] <= PC_RST;
            end else if (push && sp_q == SP_W'(si)) begin
               stk_q[si] <= pc_q + PC_W'(1);
            end
         end
      end
   endgenerate

   // file registers; execution wins over a bus write
   genvar gi;
   generate
      for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               file_q[gi] <= FILE_RST;
            end else if (to_file && f_in && ir_q.f == F_W'(gi)) begin
               file_q[gi] <= res;
            end else if (w_fdata && fsel_q == F_W'(gi)) begin
               file_q[gi] <= hwdata[7:0];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== hdl/cpx_pkg.sv ====
// constants and types for the instruction execution subset
package cpx_pkg;
   localparam int PC_W = 13;
   localparam int K_W  = 11;
   localparam int F_W  = 7;
   localparam int LT_W = 5;

   // register byte offsets
   localparam logic [7:0] A_ISSUE = 8'h00;
   localparam logic [7:0] A_ACC   = 8'h04;
   localparam logic [7:0] A_STAT  = 8'h08;
   localparam logic [7:0] A_PC    = 8'h0C;
   localparam logic [7:0] A_LATCH = 8'h10;
   localparam logic [7:0] A_TOP   = 8'h14;
   localparam logic [7:0] A_WDG   = 8'h18;
   localparam logic [7:0] A_FSEL  = 8'h1C;
   localparam logic [7:0] A_FDATA = 8'h20;

   // reset values
   localparam logic [7:0]      ACC_RST   = 8'h00;
   localparam logic [PC_W-1:0] PC_RST    = 13'h0000;
   localparam logic [LT_W-1:0] LATCH_RST = 5'h00;
   localparam logic [7:0]      FILE_RST  = 8'h00;

   // pc_upper_latch bits that feed pc bits 12:11
   localparam int LT_HI = 4;
   localparam int LT_LO = 3;

   typedef enum logic [2:0] {
      OP_NOP     = 3'h0,
      OP_WDCLR   = 3'h1,
      OP_CALL    = 3'h2,
      OP_COMP    = 3'h3,
      OP_CLR_REG = 3'h4,
      OP_CLR_ACC = 3'h5,
      OP_DEC     = 3'h6,
      OP_DECSKIP = 3'h7
   } cpx_op_t;

   // layout of a word written to the issue register
   typedef struct packed {
      logic [4:0]     rsv1;
      logic [K_W-1:0] k;
      logic [4:0]     rsv0;
      logic [F_W-1:0] f;
      logic           d;
      cpx_op_t        op;
   } cpx_instr_t;

   typedef struct packed {
      logic busy;
      logic pwrdn_n;
      logic to_n;
      logic z;
   } cpx_stat_t;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_EXEC  = 2'b01,
      S_CALL2 = 2'b11,
      S_SKIP  = 2'b10
   } cpx_state_t;
endpackage

// ==== verif/cpx_exec_chk.sv ====
// bus timing checker for the execution subset
`timescale 1ns/10ps
`default_nettype none
module cpx_exec_chk (
   input wire logic        ref_clk,   // core clock
   input wire logic        rstn,      // sync reset, active low
   input wire logic        hsel,      // slave select
   input wire logic [1:0]  htrans,    // transfer type
   input wire logic        hwrite,    // write when high
   input wire logic        hready,    // bus ready
   input wire logic [31:0] hrdata,    // read data
   input wire logic        hreadyout, // slave ready
   input wire logic        hresp      // response
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire logic tk = hsel & hready & htrans[1];
   sequence s_rd;
      tk && !hwrite;
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_read_wait: assert property (s_rd |=> s_wait)
      else $error("read wait not one cycle");
   a_write_fast: assert property (tk && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_low_once: assert property (!hreadyout |=> hreadyout)
      else $error("ready low too long");
   a_low_cause: assert property ($fell(hreadyout) |->
      $past(tk) && !$past(hwrite))
      else $error("ready low without a read");
   a_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a read");
   a_idle_high: assert property (!tk |=> hreadyout)
      else $error("ready low without a transfer");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rstn |=> hreadyout && !hresp && hrdata == 32'h0)
      else $error("bus outputs not quiet in reset");
endmodule
bind cpx_exec_core cpx_exec_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ==== verif/tb_cpx_exec_core.sv ====
// self-checking bench for the execution subset
`timescale 1ns/10ps
`default_nettype none
module tb_cpx_exec_core;
   import cpx_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] rd;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          polls = 0;
   cpx_exec_core #(.PRE_DIV(4), .WDG_W(8)) dut (.ref_clk(ref_clk),
      .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic setf(input logic [6:0] f, input logic [31:0] v);
      wr(A_FSEL, {25'h0, f});
      wr(A_FDATA, v);
   endtask
   // issue one op, then poll busy until the core is idle again
   task automatic issue(input cpx_op_t op, input logic d,
                        input logic [6:0] f, input logic [10:0] k);
      wr(A_ISSUE, {5'h0, k, 5'h0, f, d, op});
      polls = 0;
      do begin
         xfer(1'b0, A_STAT, 32'h0);
         polls++;
      end while (rd[3] !== 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      rdchk(A_ACC, 32'h0);
      rdchk(A_STAT, 32'h6);
      rdchk(A_PC, 32'h0);
      rdchk(8'h40, 32'h0);
      $display("test reset done");
      setf(7'h05, 32'hFF);
      issue(OP_COMP, 1'b1, 7'h05, 11'h0);
      rdchk(A_FDATA, 32'h0);
      rdchk(A_STAT, 32'h7);
      issue(OP_COMP, 1'b0, 7'h05, 11'h0);
      rdchk(A_ACC, 32'hFF);
      rdchk(A_FDATA, 32'h0);
      rdchk(A_STAT, 32'h6);
      $display("test complement done");
      setf(7'h06, 32'h5A);
      issue(OP_CLR_REG, 1'b1, 7'h06, 11'h0);
      rdchk(A_FDATA, 32'h0);
      rdchk(A_STAT, 32'h7);
      wr(A_STAT, 32'h6);
      issue(OP_CLR_ACC, 1'b0, 7'h00, 11'h0);
      rdchk(A_ACC, 32'h0);
      rdchk(A_STAT, 32'h7);
      $display("test clear done");
      issue(OP_DEC, 1'b0, 7'h06, 11'h0);
      rdchk(A_ACC, 32'hFF);
      rdchk(A_FDATA, 32'h0);
      rdchk(A_STAT, 32'h6);
      setf(7'h06, 32'h1);
      issue(OP_DEC, 1'b1, 7'h06, 11'h0);
      rdchk(A_FDATA, 32'h0);
      rdchk(A_STAT, 32'h7);
      $display("test decrement done");
      setf(7'h07, 32'h2);
      issue(OP_DECSKIP, 1'b1, 7'h07, 11'h0);
      chk(polls, 32'h1);
      rdchk(A_FDATA, 32'h1);
      rdchk(A_STAT, 32'h7);
      rdchk(A_PC, 32'h7);
      wr(A_STAT, 32'h6);
      issue(OP_DECSKIP, 1'b0, 7'h07, 11'h0);
      chk(polls, 32'h2);
      rdchk(A_ACC, 32'h0);
      rdchk(A_FDATA, 32'h1);
      rdchk(A_STAT, 32'h6);
      rdchk(A_PC, 32'h9);
      $display("test skip done");
      // an issue in the second call cycle must be refused
      wr(A_LATCH, 32'h18);
      wr(A_ISSUE, {5'h0, 11'h2AB, 5'h0, 7'h00, 1'b0, OP_CALL});
      issue(OP_COMP, 1'b0, 7'h05, 11'h0);
      rdchk(A_ACC, 32'h0);
      rdchk(A_PC, 32'h1AAB);
      rdchk(A_TOP, 32'hA);
      $display("test call done");
      xfer(1'b0, A_WDG, 32'h0);
      chk(32'(rd != 32'h0), 32'h1);
      wr(A_STAT, 32'h0);
      issue(OP_WDCLR, 1'b0, 7'h00, 11'h0);
      // counter restarts from zero, first tick a full prescale later
      rdchk(A_WDG, 32'h0);
      rdchk(A_WDG, 32'h1);
      rdchk(A_STAT, 32'h6);
      rdchk(A_PC, 32'h1AAC);
      $display("test watchdog done");
      // let the watchdog run out, then clear it again
      repeat (1100) @(posedge ref_clk);
      rdchk(A_STAT, 32'h4);
      issue(OP_WDCLR, 1'b0, 7'h00, 11'h0);
      rdchk(A_STAT, 32'h6);
      $display("test timeout done");
      // a byte sized write is ignored, a pc load while idle lands
      hsize <= 3'h0;
      wr(A_ACC, 32'h55);
      hsize <= 3'h2;
      rdchk(A_ACC, 32'h0);
      wr(A_PC, 32'h0123);
      rdchk(A_PC, 32'h123);
      $display("test bus done");
      stop_test();
   end
endmodule
`default_nettype wire
